// ==== src/srsa_pkg.sv ====
// Constants, opcodes and timing for the shift, rotate and subtract datapath.
// Assumes a decoder that presents one operation per request with operands.
// Function
// - Literal return loads literal, returns, six/five cycles
// - Rotate left via carry, updates C N Z
// - Rotate left no carry, updates N Z only
// - Rotate right via carry, updates C N Z
// - Rotate right no carry, updates N Z only
// - Sign extend byte, updates C N Z
// - Accumulator shift by signed amount, sets OA SA or OB SB for the selected accumulator
// - Multi-shift sets N Z; one-shift adds C OV
// - Literal-count left shift updates N Z only
// - Subtract with borrow updates C DC N OV Z
// - Non-core special register access adds one cycle
package srsa_pkg;
  // ---------------------------------------------------------------
  // Operation codes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SRSA_OP_RETURN_WITH_LITERAL = 4'h0,
    SRSA_OP_RETURN = 4'h1,
    SRSA_OP_ROTATE_LEFT_CARRY = 4'h2,
    SRSA_OP_ROTATE_LEFT_NOCARRY = 4'h3,
    SRSA_OP_ROTATE_RIGHT_CARRY = 4'h4,
    SRSA_OP_ROTATE_RIGHT_NOCARRY = 4'h5,
    SRSA_OP_SIGN_EXTEND = 4'h6,
    SRSA_OP_ACCUMULATOR_ARITH_SHIFT = 4'h7,
    SRSA_OP_SHIFT_LEFT_ONE = 4'h8,
    SRSA_OP_SHIFT_LEFT_REG = 4'h9,
    SRSA_OP_SHIFT_LEFT_LIT = 4'hA,
    SRSA_OP_SUBTRACT = 4'hB,
    SRSA_OP_SUBTRACT_WITH_BORROW = 4'hC,
    SRSA_OP_REVERSE_SUBTRACT = 4'hD,
    SRSA_OP_REVERSE_SUBTRACT_BORROW = 4'hE
  } srsa_op_t;

  // ---------------------------------------------------------------
  // Controller states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SRSA_ST_IDLE = 2'b00,
    SRSA_ST_BUSY = 2'b01,
    SRSA_ST_DONE = 2'b11
  } srsa_state_t;

  // ---------------------------------------------------------------
  // Cycle counts and field layout
  // ---------------------------------------------------------------
  localparam logic [2:0] SRSA_RET_CYCLES = 3'h6;
  localparam logic [2:0] SRSA_RET_CYCLES_SHORT = 3'h5;
  localparam logic [2:0] SRSA_BASE_CYCLES = 3'h1;
  localparam logic [2:0] SRSA_SFR_EXTRA = 3'h1;
  localparam int SRSA_BYTE_SIGN_BIT = 7;
  localparam int SRSA_DIGIT_BIT = 4;
  localparam int SRSA_SIGNED_SIX_BIT_LITERAL_W = 6;
  localparam int SRSA_FIVE_BIT_LITERAL_W = 5;
  localparam logic [4:0] SRSA_FLAGS_RESET = 5'h00;
endpackage

// ==== src/srsa_alu.sv ====
// Shift, rotate, sign-extend, accumulator-shift, subtract and return datapath.
// Assumes the decoder holds req for one cycle with op and operands valid.
`timescale 1ns/10ps
`default_nettype none
module srsa_alu #(
  parameter int DW = 16,
  parameter int AW = 40
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Request from decoder
  input wire logic req,
  input wire srsa_pkg::srsa_op_t op,
  input wire logic [DW-1:0] opnd_a,
  input wire logic [DW-1:0] opnd_b,
  input wire logic use_literal_amount,
  input wire logic [5:0] signed_six_bit_literal,
  input wire logic [4:0] five_bit_literal,
  input wire logic [9:0] return_literal,
  input wire logic acc_sel,
  input wire logic acc_load,
  input wire logic [AW-1:0] acc_load_data,
  input wire logic short_return,
  input wire logic sfr_access,
  // Result
  output logic busy,
  output logic done,
  output logic [DW-1:0] result,
  output logic result_we,
  output logic return_pop,
  // Status flags
  output logic flag_c,
  output logic flag_dc,
  output logic flag_n,
  output logic flag_ov,
  output logic flag_z,
  // Accumulators
  output logic [AW-1:0] acc_a,
  output logic [AW-1:0] acc_b,
  output logic [1:0] acc_ovf,
  output logic [1:0] acc_sat
);
  import srsa_pkg::*;

  // ---------------------------------------------------------------
  // Combinational datapath
  // ---------------------------------------------------------------
  logic [DW-1:0] res_next;
  logic c_next, dc_next, n_next, ov_next, z_next;
  logic upd_c, upd_dc, upd_ov, upd_nz, wr_next;
  logic [DW:0] diff;
  logic [4:0] dlow;
  logic [DW-1:0] sub_x, sub_y;
  logic sub_bin;
  logic carry_in;
  logic signed [6:0] amt;
  logic [AW-1:0] acc_in, acc_sh;
  logic signed [AW+31:0] acc_wide;
  logic [4:0] shamt;

  // Subtract operand routing: x - y - borrow
  always_comb begin
    sub_x = opnd_a;
    sub_y = opnd_b;
    sub_bin = 1'b0;
    unique case (op)
      SRSA_OP_SUBTRACT_WITH_BORROW: sub_bin = ~carry_in;
      SRSA_OP_REVERSE_SUBTRACT: begin
        sub_x = opnd_b;
        sub_y = opnd_a;
      end
      SRSA_OP_REVERSE_SUBTRACT_BORROW: begin
        sub_x = opnd_b;
        sub_y = opnd_a;
        sub_bin = ~carry_in;
      end
      default: sub_bin = 1'b0;
    endcase
    diff = {1'b0, sub_x} - {1'b0, sub_y} - {{DW{1'b0}}, sub_bin};
    dlow = {1'b0, sub_x[3:0]} - {1'b0, sub_y[3:0]} - {4'h0, sub_bin};
  end

  // Accumulator shift amount: positive shifts right, negative left
  always_comb begin
    if (use_literal_amount) begin
      amt = {signed_six_bit_literal[SRSA_SIGNED_SIX_BIT_LITERAL_W-1], signed_six_bit_literal};
    end else begin
      amt = {opnd_a[SRSA_SIGNED_SIX_BIT_LITERAL_W-1], opnd_a[SRSA_SIGNED_SIX_BIT_LITERAL_W-1:0]};
    end
    acc_in = acc_sel ? acc_b : acc_a;
    if (amt[6]) begin
      acc_wide = $signed({{32{acc_in[AW-1]}}, acc_in}) <<< (7'(-amt));
    end else begin
      acc_wide = $signed({{32{acc_in[AW-1]}}, acc_in}) >>> amt;
    end
    acc_sh = acc_wide[AW-1:0];
  end

  // Result and flag selection per operation
  always_comb begin
    res_next = opnd_a;
    c_next = flag_c;
    dc_next = flag_dc;
    ov_next = flag_ov;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_ov = 1'b0;
    upd_nz = 1'b1;
    wr_next = 1'b1;
    shamt = use_literal_amount ? five_bit_literal : opnd_b[4:0];
    unique case (op)
      SRSA_OP_RETURN_WITH_LITERAL: begin
        res_next = DW'(return_literal);
        upd_nz = 1'b0;
      end
      SRSA_OP_RETURN: begin
        upd_nz = 1'b0;
        wr_next = 1'b0;
      end
      SRSA_OP_ROTATE_LEFT_CARRY: begin
        res_next = {opnd_a[DW-2:0], carry_in};
        c_next = opnd_a[DW-1];
        upd_c = 1'b1;
      end
      SRSA_OP_ROTATE_LEFT_NOCARRY: res_next = {opnd_a[DW-2:0], opnd_a[DW-1]};
      SRSA_OP_ROTATE_RIGHT_CARRY: begin
        res_next = {carry_in, opnd_a[DW-1:1]};
        c_next = opnd_a[0];
        upd_c = 1'b1;
      end
      SRSA_OP_ROTATE_RIGHT_NOCARRY: res_next = {opnd_a[0], opnd_a[DW-1:1]};
      SRSA_OP_SIGN_EXTEND: begin
        res_next = {{(DW-8){opnd_a[SRSA_BYTE_SIGN_BIT]}}, opnd_a[7:0]};
        c_next = ~opnd_a[SRSA_BYTE_SIGN_BIT];
        upd_c = 1'b1;
      end
      SRSA_OP_ACCUMULATOR_ARITH_SHIFT: begin
        upd_nz = 1'b0;
        wr_next = 1'b0;
      end
      SRSA_OP_SHIFT_LEFT_ONE: begin
        res_next = {opnd_a[DW-2:0], 1'b0};
        c_next = opnd_a[DW-1];
        ov_next = opnd_a[DW-1] ^ opnd_a[DW-2];
        upd_c = 1'b1;
        upd_ov = 1'b1;
      end
      SRSA_OP_SHIFT_LEFT_REG, SRSA_OP_SHIFT_LEFT_LIT: res_next = opnd_a << shamt;
      default: begin
        res_next = diff[DW-1:0];
        c_next = ~diff[DW];
        dc_next = ~dlow[SRSA_DIGIT_BIT];
        ov_next = (sub_x[DW-1] ^ sub_y[DW-1]) & (sub_x[DW-1] ^ diff[DW-1]);
        upd_c = 1'b1;
        upd_dc = 1'b1;
        upd_ov = 1'b1;
      end
    endcase
    n_next = res_next[DW-1];
    z_next = (res_next == '0);
  end

  // ---------------------------------------------------------------
  // Sequencing: cycle count per instruction
  // ---------------------------------------------------------------
  srsa_state_t state_reg;
  logic [2:0] cnt_reg;
  logic [2:0] cycles;
  logic is_ret;

  always_comb begin
    is_ret = (op == SRSA_OP_RETURN_WITH_LITERAL) || (op == SRSA_OP_RETURN);
    if (is_ret) begin
      cycles = short_return ? SRSA_RET_CYCLES_SHORT : SRSA_RET_CYCLES;
    end else begin
      cycles = SRSA_BASE_CYCLES;
    end
    if (sfr_access) begin
      cycles = cycles + SRSA_SFR_EXTRA;
    end
  end

  assign busy = (state_reg == SRSA_ST_BUSY);

  // State and remaining-cycle counter; result is committed on the last cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= SRSA_ST_IDLE;
      cnt_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        SRSA_ST_IDLE, SRSA_ST_DONE: begin
          if (req && cycles > SRSA_BASE_CYCLES) begin
            state_reg <= SRSA_ST_BUSY;
            cnt_reg <= cycles - 3'h2;
          end else if (req) begin
            state_reg <= SRSA_ST_DONE;
          end else begin
            state_reg <= SRSA_ST_IDLE;
          end
        end
        SRSA_ST_BUSY: begin
          if (cnt_reg == 3'h0) begin
            state_reg <= SRSA_ST_DONE;
          end else begin
            cnt_reg <= cnt_reg - 3'h1;
          end
        end
        default: state_reg <= SRSA_ST_IDLE;
      endcase
    end
  end

  // Latch the computed outcome at request time
  logic [DW-1:0] res_hold;
  logic [4:0] flg_hold, upd_hold;
  logic wr_hold, ret_hold;
  always_ff @(posedge mclk) begin
    if (srst) begin
      res_hold <= '0;
      flg_hold <= SRSA_FLAGS_RESET;
      upd_hold <= 5'h00;
      wr_hold <= 1'b0;
      ret_hold <= 1'b0;
    end else if (req && state_reg != SRSA_ST_BUSY) begin
      res_hold <= res_next;
      flg_hold <= {c_next, dc_next, n_next, ov_next, z_next};
      upd_hold <= {upd_c, upd_dc, upd_nz, upd_ov, upd_nz};
      wr_hold <= wr_next;
      ret_hold <= is_ret;
    end
  end

  // Finishing pulse: one cycle after the last busy cycle
  logic fin;
  assign fin = (state_reg == SRSA_ST_DONE);
  // Carry for a new request: a commit landing on this edge beats the stale flag
  assign carry_in = (fin && upd_hold[4]) ? flg_hold[4] : flag_c;

  // Outputs driven from registers at completion
  always_ff @(posedge mclk) begin
    if (srst) begin
      done <= 1'b0;
      result <= '0;
      result_we <= 1'b0;
      return_pop <= 1'b0;
    end else begin
      done <= fin;
      result_we <= fin & wr_hold;
      return_pop <= fin & ret_hold;
      if (fin && wr_hold) begin
        result <= res_hold;
      end
    end
  end

  // Status flags update only where the operation touches them
  always_ff @(posedge mclk) begin
    if (srst) begin
      {flag_c, flag_dc, flag_n, flag_ov, flag_z} <= SRSA_FLAGS_RESET;
    end else if (fin) begin
      if (upd_hold[4]) flag_c <= flg_hold[4];
      if (upd_hold[3]) flag_dc <= flg_hold[3];
      if (upd_hold[2]) flag_n <= flg_hold[2];
      if (upd_hold[1]) flag_ov <= flg_hold[1];
      if (upd_hold[0]) flag_z <= flg_hold[0];
    end
  end

  // Accumulator shift with overflow and saturation flags
  logic acc_lost;
  assign acc_lost = (acc_wide[AW+31:AW-1] != {(33){acc_wide[AW-1]}});
  always_ff @(posedge mclk) begin
    if (srst) begin
      acc_a <= '0;
      acc_b <= '0;
      acc_ovf <= 2'h0;
      acc_sat <= 2'h0;
    end else if (acc_load) begin
      if (acc_sel) begin
        acc_b <= acc_load_data; // Decoder preloads the selected accumulator
      end else begin
        acc_a <= acc_load_data;
      end
    end else if (req && !busy && op == SRSA_OP_ACCUMULATOR_ARITH_SHIFT) begin
      if (acc_sel) begin
        acc_b <= acc_lost ? {acc_in[AW-1], {(AW-1){~acc_in[AW-1]}}} : acc_sh;
        acc_ovf[1] <= acc_lost;
        acc_sat[1] <= acc_sat[1] | acc_lost;
      end else begin
        acc_a <= acc_lost ? {acc_in[AW-1], {(AW-1){~acc_in[AW-1]}}} : acc_sh;
        acc_ovf[0] <= acc_lost;
        acc_sat[0] <= acc_sat[0] | acc_lost;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/srsa_alu_assertions.sv ====
// Checker: result, carry and latency relations at the datapath ports.
// Assumes binding to srsa_alu; watches only its ports.
`timescale 1ns/10ps
`default_nettype none
module srsa_alu_assertions #(
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Request
  input wire logic req,
  input wire srsa_pkg::srsa_op_t op,
  input wire logic [DW-1:0] opnd_a,
  input wire logic [DW-1:0] opnd_b,
  input wire logic [4:0] five_bit_literal,
  input wire logic use_literal_amount,
  input wire logic short_return,
  input wire logic sfr_access,
  // Outputs
  input wire logic busy,
  input wire logic done,
  input wire logic return_pop,
  input wire logic [DW-1:0] result,
  input wire logic flag_c
);
  import srsa_pkg::*;
  // ----------
  // Takes without special register access
  // ----------
  logic take;
  assign take = req && !busy && !sfr_access;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  a_rotl_nocarry: assert property (
    take && op == SRSA_OP_ROTATE_LEFT_NOCARRY |-> ##2 done && flag_c == $past(flag_c, 1)
    && result == {$past(opnd_a[DW-2:0], 2), $past(opnd_a[DW-1], 2)}) else $error("rotate_left_nocarry bad");
  a_rotl_carry: assert property (
    take && op == SRSA_OP_ROTATE_LEFT_CARRY |-> ##2 flag_c == $past(opnd_a[DW-1], 2)
    && result == {$past(opnd_a[DW-2:0], 2), $past(flag_c, 1)}) else $error("rlc bad");
  a_rotr_carry: assert property (
    take && op == SRSA_OP_ROTATE_RIGHT_CARRY |-> ##2 flag_c == $past(opnd_a[0], 2)
    && result == {$past(flag_c, 1), $past(opnd_a[DW-1:1], 2)}) else $error("rrc bad");
  a_sign_extend: assert property (
    take && op == SRSA_OP_SIGN_EXTEND |-> ##2 flag_c == !result[7]
    && result == {{(DW-8){$past(opnd_a[7], 2)}}, $past(opnd_a[7:0], 2)}) else $error("se bad");
  a_sub_borrow: assert property (
    take && op == SRSA_OP_SUBTRACT_WITH_BORROW |-> ##2
    result == $past(opnd_a, 2) - $past(opnd_b, 2) - !$past(flag_c, 1)) else $error("subtract_with_borrow bad");
  a_reverse_sub: assert property (
    take && op == SRSA_OP_REVERSE_SUBTRACT |-> ##2
    result == $past(opnd_b, 2) - $past(opnd_a, 2)) else $error("reverse_subtract bad");
  a_shift_literal: assert property (
    take && op == SRSA_OP_SHIFT_LEFT_LIT && use_literal_amount |-> ##2
    result == $past(opnd_a, 2) << $past(five_bit_literal, 2)) else $error("sl lit bad");
  a_return_latency: assert property (
    take && op == SRSA_OP_RETURN && !short_return |-> !done [*7] ##1 done && return_pop)
    else $error("return latency bad");
  a_sfr_extra: assert property (
    req && !busy && sfr_access && op == SRSA_OP_SUBTRACT |-> !done [*3] ##1 done)
    else $error("sfr latency bad");
endmodule
bind srsa_alu srsa_alu_assertions #(.DW(DW)) chk_u (.mclk(mclk), .srst(srst), .req(req),
  .op(op), .opnd_a(opnd_a), .opnd_b(opnd_b), .five_bit_literal(five_bit_literal),
  .use_literal_amount(use_literal_amount), .short_return(short_return),
  .sfr_access(sfr_access), .busy(busy), .done(done), .return_pop(return_pop),
  .result(result), .flag_c(flag_c));
`default_nettype wire

// ==== verif/srsa_decoder_model.sv ====
// Decoder stand-in: one operation with its operands per request.
// Assumes the datapath takes a request on an edge where busy is low.
`timescale 1ns/10ps
`default_nettype none
module srsa_decoder_model (
  // Clock and status
  input wire logic mclk,
  input wire logic busy,
  // Request and operands
  output logic req,
  output srsa_pkg::srsa_op_t op,
  output logic [15:0] opnd_a,
  output logic [15:0] opnd_b,
  output logic use_literal_amount,
  output logic [5:0] signed_six_bit_literal,
  output logic [4:0] five_bit_literal,
  output logic [9:0] return_literal,
  output logic acc_sel,
  output logic short_return,
  output logic sfr_access,
  output logic acc_load,
  output logic [39:0] acc_load_data
);
  import srsa_pkg::*;
  // Idle request lines from time zero
  initial begin
    req = 1'b0;
    op = SRSA_OP_RETURN;
    {opnd_a, opnd_b, use_literal_amount, signed_six_bit_literal} = '0;
    {five_bit_literal, return_literal, acc_sel, short_return, sfr_access, acc_load} = '0;
    acc_load_data = '0;
  end
  // Hold a request to its taking edge, then scramble the operands
  task automatic issue(input srsa_op_t o, input logic [15:0] x, y, input logic sh, sf);
    int n;
    n = 0;
    @(posedge mclk);
    while (busy !== 1'b0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    {signed_six_bit_literal, five_bit_literal, return_literal, acc_sel} <= 22'($urandom);
    // Preload the selected accumulator one cycle ahead of an accumulator shift
    if (o == SRSA_OP_ACCUMULATOR_ARITH_SHIFT) begin
      acc_load <= 1'b1;
      acc_load_data <= {8'($urandom), $urandom};
      @(posedge mclk);
      acc_load <= 1'b0;
    end
    req <= 1'b1;
    op <= o;
    opnd_a <= x;
    opnd_b <= y;
    use_literal_amount <= (o == SRSA_OP_SHIFT_LEFT_LIT) ||
      (o == SRSA_OP_ACCUMULATOR_ARITH_SHIFT && sh);
    short_return <= sh;
    sfr_access <= sf;
    @(posedge mclk);
    req <= 1'b0;
    opnd_a <= ~x;
    opnd_b <= ~y;
  endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Bench: decoder model issues every operation, a reference model checks.
// Assumes srsa_pkg, srsa_alu and srsa_decoder_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import srsa_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic req, busy, done, result_we, return_pop, use_literal_amount, acc_sel, short_return;
  logic sfr_access, flag_c, flag_dc, flag_n, flag_ov, flag_z;
  srsa_op_t op;
  logic [15:0] opnd_a, opnd_b, result;
  logic [5:0] signed_six_bit_literal;
  logic [4:0] five_bit_literal;
  logic [9:0] return_literal;
  logic [39:0] acc_a, acc_b, acc_load_data;
  logic [1:0] acc_ovf, acc_sat;
  logic [4:0] mf = 5'h00;
  logic [1:0] ms = 2'h0;
  logic acc_load;
  int num_errors = 0;
  int num_checks = 0;
  // ----------
  // Clock, design and decoder
  // ----------
  always #50 mclk = ~mclk;
  srsa_alu dut_u (.mclk, .srst, .req, .op, .opnd_a, .opnd_b, .use_literal_amount,
    .signed_six_bit_literal, .five_bit_literal, .return_literal, .acc_sel, .short_return,
    .sfr_access, .busy, .done, .result, .result_we, .return_pop, .flag_c, .flag_dc,
    .flag_n, .flag_ov, .flag_z, .acc_a, .acc_b, .acc_ovf, .acc_sat, .acc_load, .acc_load_data);
  srsa_decoder_model dec_u (.mclk, .busy, .req, .op, .opnd_a, .opnd_b, .use_literal_amount,
    .signed_six_bit_literal, .five_bit_literal, .return_literal, .acc_sel, .short_return,
    .sfr_access, .acc_load, .acc_load_data);
  // Compare and count
  task automatic check(input logic [39:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Issue one operation, wait for completion, compare with the model
  task automatic run(input srsa_op_t o, input logic [15:0] x, y, input logic sh, sf);
    logic [15:0] p, q, r;
    logic [16:0] d;
    logic signed [79:0] w;
    logic signed [6:0] s;
    logic [39:0] ea;
    logic [4:0] fl;
    logic c, wr, lost;
    int bin, cnt, ec;
    cnt = 0;
    c = mf[4];
    lost = 1'b0;
    ea = '0;
    dec_u.issue(o, x, y, sh, sf);
    r = {6'h00, return_literal};
    wr = !(o inside {SRSA_OP_RETURN, SRSA_OP_ACCUMULATOR_ARITH_SHIFT});
    case (o)
      SRSA_OP_ROTATE_LEFT_CARRY: {c, r} = {x, c};
      SRSA_OP_ROTATE_RIGHT_CARRY: {r, c} = {c, x};
      SRSA_OP_ROTATE_LEFT_NOCARRY: r = {x[14:0], x[15]};
      SRSA_OP_ROTATE_RIGHT_NOCARRY: r = {x[0], x[15:1]};
      SRSA_OP_SIGN_EXTEND: {r, c} = {{8{x[7]}}, x[7:0], !x[7]};
      SRSA_OP_SHIFT_LEFT_ONE: {c, r, mf[1]} = {x, 1'b0, x[15] ^ x[14]};
      SRSA_OP_SHIFT_LEFT_REG: r = x << y[4:0];
      SRSA_OP_SHIFT_LEFT_LIT: r = x << five_bit_literal;
      SRSA_OP_RETURN_WITH_LITERAL, SRSA_OP_RETURN: ;
      SRSA_OP_ACCUMULATOR_ARITH_SHIFT: begin
        // Signed amount: positive shifts right, negative left; lost bits saturate
        s = sh ? {signed_six_bit_literal[5], signed_six_bit_literal} : {x[5], x[5:0]};
        w = {{40{acc_load_data[39]}}, acc_load_data};
        if (s < 0) w = w <<< (-s);
        else w = w >>> s;
        lost = (w[79:39] != {41{w[39]}});
        ea = lost ? {acc_load_data[39], {39{~acc_load_data[39]}}} : w[39:0];
        ms[acc_sel] = ms[acc_sel] | lost;
      end
      default: begin
        {p, q} = (o < SRSA_OP_REVERSE_SUBTRACT) ? {x, y} : {y, x};
        bin = (o inside {SRSA_OP_SUBTRACT_WITH_BORROW, SRSA_OP_REVERSE_SUBTRACT_BORROW}) && !c;
        d = {1'b0, p} - {1'b0, q} - 17'(bin);
        {c, r} = {!d[16], d[15:0]};
        mf[3] = int'(p[3:0]) >= int'(q[3:0]) + bin;
        mf[1] = (p[15] ^ q[15]) & (p[15] ^ r[15]);
      end
    endcase
    if (wr && o > SRSA_OP_RETURN) mf = {c, mf[3], r[15], mf[1], r == 16'h0000};
    do begin
      @(posedge mclk);
      cnt++;
    end while (done !== 1'b1 && cnt < 20);
    ec = ((o < SRSA_OP_ROTATE_LEFT_CARRY) ? (sh ? 5 : 6) : 1) + sf + 1;
    fl = {flag_c, flag_dc, flag_n, flag_ov, flag_z};
    check(40'(cnt), 40'(ec));
    check({return_pop, result_we}, {o < SRSA_OP_ROTATE_LEFT_CARRY, wr});
    if (wr) check(result, r);
    check(fl, mf);
    if (o == SRSA_OP_ACCUMULATOR_ARITH_SHIFT) begin
      check(acc_sel ? acc_b : acc_a, ea);
      check({acc_ovf[acc_sel], acc_sat[acc_sel]}, {lost, ms[acc_sel]});
    end
    $display("op %0d finished", o);
  endtask
  // Reset, a boundary subtract, then every operation with random operands
  initial begin
    void'($urandom(32'h3E3F8A16));
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    run(SRSA_OP_SUBTRACT, 16'h8000, 16'h0001, 1'b0, 1'b0);
    for (int k = 0; k < 45; k++) begin
      run(srsa_op_t'(k % 15), 16'($urandom), 16'($urandom), k[0], k >= 30);
    end
    finish_test();
  end
  // Watchdog: the run needs well under a thousand cycles
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
